// ===== bench/cnsi_master_mdl.sv
// cnsi_master_mdl: network master issuing decoded requests
// assumes the node samples requests on rising edges
`timescale 1ns/1ps
module cnsi_master_mdl
    import cnsi_pkg::*;
#(
    parameter logic [31:0] VID = 32'h0,
    parameter logic [31:0] PID = 32'h0,
    parameter logic [31:0] REV = 32'h0
) (
    input  wire logic sys_clk_i,
    output cnsi_req_t req_o
);
    initial req_o = '0;
    // idle shows scrambled data so stale fields are never trusted
    task automatic send(input cnsi_req_t q);
        cnsi_req_t t;
        @(negedge sys_clk_i);
        req_o = q;
        @(negedge sys_clk_i);
        t = cnsi_req_t'(~q);
        t.nmt_vld = 1'b0;
        t.lss_cmd = LSS_NONE;
        req_o = t;
    endtask
    // once out of Init, state changes only by management commands
    task automatic nmt(input logic [7:0] c, input logic [6:0] d);
        cnsi_req_t q;
        q = '0;
        q.nmt_vld = 1'b1;
        q.nmt_cmd = c;
        q.nmt_dst = d;
        send(q);
    endtask
    // identity sent with every layer command
    task automatic lss(input cnsi_lsscmd_t c, input logic [6:0] id,
                       input logic [3:0] bt, input logic [31:0] ser);
        cnsi_req_t q;
        q = '0;
        q.lss_cmd = c;
        q.new_id = id;
        q.new_bt = bt;
        q.vendor = VID;
        q.product = PID;
        q.revision = REV;
        q.serial = ser;
        send(q);
    endtask
endmodule // cnsi_master_mdl

// ===== bench/cnsi_node_asserts.sv
// cnsi_node_asserts: port checks of the node supervision block
// assumes one clock domain and an active-low async reset
`timescale 1ns/1ps
module cnsi_node_asserts
    import cnsi_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        rstn_i,
    input wire logic        clk_en_i,
    input wire cnsi_req_t   req_i,
    input wire logic        remap_req_i,
    input wire logic        tpdo_req_i,
    input wire logic [31:0] meas_i,
    input wire logic        fatal_i,
    input wire logic        bus_off_i,
    input wire logic [6:0]  node_id_o,
    input wire logic [3:0]  rate_idx_o,
    input wire cnsi_nmt_t   nmt_state_o,
    input wire cnsi_ind_t   ind_o,
    input wire logic        tpdo_vld_o,
    input wire logic [31:0] tpdo_data_o,
    input wire logic        run_green_o,
    input wire logic        run_red_o,
    input wire logic        err_red_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_rst_init;
        $rose(rstn_i) |-> nmt_state_o == CNSI_INIT
            && node_id_o == NODE_ID_RST && rate_idx_o == RATE_IDX_RST;
    endproperty
    a_rst_init: assert property (p_rst_init)
        else $error("reset state wrong");
    property p_start;
        clk_en_i && req_i.nmt_vld && req_i.nmt_cmd == NMT_START
            && req_i.nmt_dst == 7'h00 && nmt_state_o != CNSI_INIT
            |=> nmt_state_o == CNSI_OPER;
    endproperty
    a_start: assert property (p_start)
        else $error("start ignored");
    property p_gate;
        ind_o.tpdo_en == (nmt_state_o == CNSI_OPER)
            && ind_o.rpdo_en == ind_o.tpdo_en
            && ind_o.sdo_en == (nmt_state_o inside {CNSI_PREOP, CNSI_OPER});
    endproperty
    a_gate: assert property (p_gate)
        else $error("service gating wrong");
    property p_tpdo;
        clk_en_i && tpdo_req_i && ind_o.tpdo_en
            |=> tpdo_vld_o && tpdo_data_o == $past(meas_i);
    endproperty
    a_tpdo: assert property (p_tpdo)
        else $error("measurement not sent");
    property p_remap;
        clk_en_i && remap_req_i |=> ind_o.remap_nak;
    endproperty
    a_remap: assert property (p_remap)
        else $error("remap not refused");
    property p_fatal;
        (clk_en_i && fatal_i) [*2] |=> run_red_o && !run_green_o;
    endproperty
    a_fatal: assert property (p_fatal)
        else $error("fatal lamp wrong");
    property p_bus_off;
        (clk_en_i && bus_off_i) [*2] |=> err_red_o;
    endproperty
    a_bus_off: assert property (p_bus_off)
        else $error("bus off lamp wrong");
    property p_setid_bad;
        clk_en_i && req_i.lss_cmd == LSS_SETID && req_i.new_id == 7'h00
            |=> ind_o.lss_err && !ind_o.lss_ok;
    endproperty
    a_setid_bad: assert property (p_setid_bad)
        else $error("bad id accepted");
    property p_wait_apply;
        $changed(node_id_o) |-> $past(req_i.lss_cmd) == LSS_WAITC;
    endproperty
    a_wait_apply: assert property (p_wait_apply)
        else $error("id changed early");
endmodule // cnsi_node_asserts

// ===== bench/cnsi_node_tb.sv
// cnsi_node_tb: self-checking bench of the node supervision block
// assumes short lamp counts; inputs change on falling edges
`timescale 1ns/1ps
module cnsi_node_tb;
    import cnsi_pkg::*;
    localparam int BLK = 8;
    localparam logic [31:0] VID = 32'h0000_0C3D; // arbitrary
    localparam logic [31:0] PID = 32'h0000_0042; // arbitrary
    localparam logic [31:0] REV = 32'h0000_0007; // arbitrary
    logic sys_clk_i = 1'b0, rstn_i = 1'b0;
    logic tpdo_req_i = 1'b0, rpdo_vld_i = 1'b0, remap_req_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [4:0] err_in = 5'h00;
    logic [31:0] serial_i = 32'h0, meas_i = 32'h0, rpdo_data_i = 32'h0;
    logic [31:0] v, g, r, e, tpdo_data_o, setp_o;
    logic [6:0] node_id_o, nid;
    logic [3:0] rate_idx_o, rt;
    logic tpdo_vld_o, setp_vld_o, run_green_o, run_red_o, err_red_o;
    cnsi_req_t req;
    cnsi_nmt_t nmt_state_o;
    cnsi_ind_t ind_o;
    int miscompares = 0, num_checks = 0, seed = 85561, cyc = 0, i;
    int gp[5] = '{0, 12, 12, 0, 6};
    int rp[5] = '{12, 0, 0, 12, 0};
    int ep[5] = '{12, 2, 1, 0, 0};
    cnsi_master_mdl #(.VID(VID), .PID(PID), .REV(REV)) u_mst (
        .sys_clk_i(sys_clk_i), .req_o(req));
    cnsi_node #(.VENDOR_ID(VID), .PRODUCT_ID(PID), .REVISION(REV),
        .FLICK_CYC(4), .BLINK_CYC(BLK)) u_dut (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
        .req_i(req), .serial_i(serial_i), .remap_req_i(remap_req_i),
        .tpdo_req_i(tpdo_req_i), .meas_i(meas_i), .rpdo_vld_i(rpdo_vld_i),
        .rpdo_data_i(rpdo_data_i), .rate_detect_i(err_in[4]),
        .fatal_i(err_in[3]), .bus_warn_i(err_in[2]),
        .err_ctrl_i(err_in[1]), .bus_off_i(err_in[0]),
        .node_id_o(node_id_o), .rate_idx_o(rate_idx_o),
        .nmt_state_o(nmt_state_o), .ind_o(ind_o), .tpdo_vld_o(tpdo_vld_o),
        .tpdo_data_o(tpdo_data_o), .setp_vld_o(setp_vld_o),
        .setp_o(setp_o), .run_green_o(run_green_o),
        .run_red_o(run_red_o), .err_red_o(err_red_o));
    always #25 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            miscompares++;
            close_out;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [1:0] bt_exp(input int b);
        return (b <= 8) ? 2'b10 : 2'b01;
    endfunction
    // a whole blink cycle makes the counts independent of phase
    task automatic lampchk(input int gph, input int rph, input int eph);
        g = 0;
        r = 0;
        e = 0;
        repeat (2) @(negedge sys_clk_i);
        repeat (12 * BLK) begin
            @(negedge sys_clk_i);
            g = g + run_green_o;
            r = r + run_red_o;
            e = e + err_red_o;
        end
        chk(g, 32'(gph * BLK));
        chk(r, 32'(rph * BLK));
        chk(e, 32'(eph * BLK));
    endtask
    task automatic close_out;
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        serial_i = $random(seed);
        repeat (10) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        chk({node_id_o, rate_idx_o}, {7'h70, 4'h8});
        chk(nmt_state_o, CNSI_INIT);
        @(negedge sys_clk_i);
        chk({nmt_state_o, ind_o[5:3]}, {CNSI_PREOP, 3'b100});
        lampchk(6, 0, 0);
        u_mst.nmt(NMT_START, 7'h00);
        chk({nmt_state_o, ind_o[5:3]}, {CNSI_OPER, 3'b111});
        repeat (24) begin
            v = $random(seed);
            meas_i = v;
            rpdo_data_i = ~v; // set-points only by process data
            {tpdo_req_i, rpdo_vld_i, remap_req_i} = v[2:0];
            @(negedge sys_clk_i);
            chk({tpdo_vld_o, setp_vld_o, ind_o.remap_nak}, v[2:0]);
            if (v[2]) chk(tpdo_data_o, v);
            if (v[1]) chk(setp_o, ~v);
        end
        {tpdo_req_i, rpdo_vld_i, remap_req_i} = 3'b000;
        for (i = 0; i < 5; i++) begin
            err_in = 5'h01 << i;
            lampchk(gp[i], rp[i], ep[i]);
        end
        err_in = 5'h00;
        // a low enable must freeze the state even for a valid command
        clk_en_i = 1'b0;
        u_mst.nmt(NMT_STOP, 7'h00);
        chk(nmt_state_o, CNSI_OPER);
        clk_en_i = 1'b1;
        u_mst.nmt(NMT_STOP, 7'h71);
        chk(nmt_state_o, CNSI_OPER);
        u_mst.nmt(NMT_STOP, 7'h00);
        chk({nmt_state_o, ind_o[5:3]}, {CNSI_STOPPED, 3'b000});
        lampchk(1, 0, 0);
        u_mst.nmt(NMT_PREOP, 7'h70);
        chk(nmt_state_o, CNSI_PREOP);
        for (i = 0; i < 2; i++) begin
            u_mst.nmt(i ? NMT_RST_COMM : NMT_RST_NODE, 7'h00);
            chk(nmt_state_o, CNSI_INIT);
            @(negedge sys_clk_i);
            chk(nmt_state_o, CNSI_PREOP);
        end
        u_mst.lss(LSS_SETID, 7'h33, 4'h0, serial_i);
        chk(ind_o[1:0], 2'b01);
        u_mst.lss(LSS_SEL, 7'h00, 4'h0, ~serial_i);
        u_mst.lss(LSS_SETID, 7'h33, 4'h0, serial_i);
        chk(ind_o[1:0], 2'b01);
        u_mst.lss(LSS_SEL, 7'h00, 4'h0, serial_i);
        chk(ind_o[1:0], 2'b10);
        lampchk(6, 0, 6);
        for (i = 0; i < 10; i++) begin
            u_mst.lss(LSS_SETBT, 7'h00, 4'(i), serial_i);
            chk(ind_o[1:0], bt_exp(i));
        end
        v = $random(seed);
        nid = v[6:0] % 7'h7E + 7'h01;
        rt = v[11:8] % 4'h9;
        u_mst.lss(LSS_SETID, 7'h00, 4'h0, serial_i);
        chk(ind_o[1:0], 2'b01);
        u_mst.lss(LSS_SETID, nid, 4'h0, serial_i);
        u_mst.lss(LSS_SETBT, 7'h00, rt, serial_i);
        u_mst.lss(LSS_STORE, 7'h00, 4'h0, serial_i);
        chk({ind_o[1:0], node_id_o}, {2'b10, 7'h70});
        u_mst.lss(LSS_WAITC, 7'h00, 4'h0, serial_i);
        chk({node_id_o, rate_idx_o}, {nid, rt});
        u_mst.lss(LSS_GLOB, 7'h00, 4'h0, serial_i);
        u_mst.lss(LSS_SETID, 7'h7F, 4'h0, serial_i);
        u_mst.lss(LSS_STORE, 7'h00, 4'h0, serial_i);
        u_mst.lss(LSS_WAITC, 7'h00, 4'h0, serial_i);
        chk(node_id_o, 7'h7F);
        lampchk(6, 0, 0);
        close_out;
    end
endmodule // cnsi_node_tb
bind cnsi_node cnsi_node_asserts u_chk (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
    .req_i(req_i), .remap_req_i(remap_req_i), .tpdo_req_i(tpdo_req_i),
    .meas_i(meas_i), .fatal_i(fatal_i), .bus_off_i(bus_off_i),
    .node_id_o(node_id_o), .rate_idx_o(rate_idx_o),
    .nmt_state_o(nmt_state_o), .ind_o(ind_o), .tpdo_vld_o(tpdo_vld_o),
    .tpdo_data_o(tpdo_data_o), .run_green_o(run_green_o),
    .run_red_o(run_red_o), .err_red_o(err_red_o));

// ===== logic/cnsi_node.sv
// cnsi_node: management state, layer setting and status lamp logic
// assumes frames are already decoded into one-cycle request strobes
`timescale 1ns/1ps
module cnsi_node #(
    parameter logic [31:0] VENDOR_ID  = 32'h0000_00A5, // arbitrary
    parameter logic [31:0] PRODUCT_ID = 32'h0000_0011, // arbitrary
    parameter logic [31:0] REVISION   = 32'h0000_0001, // arbitrary
    parameter int unsigned FLICK_CYC  = cnsi_pkg::FLICKER_CYC,
    parameter int unsigned BLINK_CYC  = cnsi_pkg::BLINK_CYC
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rstn_i,
    input  wire logic              clk_en_i,
    input  wire cnsi_pkg::cnsi_req_t req_i,
    input  wire logic [31:0]       serial_i,
    input  wire logic              remap_req_i,
    input  wire logic              tpdo_req_i,
    input  wire logic [31:0]       meas_i,
    input  wire logic              rpdo_vld_i,
    input  wire logic [31:0]       rpdo_data_i,
    input  wire logic              rate_detect_i,
    input  wire logic              fatal_i,
    input  wire logic              bus_warn_i,
    input  wire logic              err_ctrl_i,
    input  wire logic              bus_off_i,
    output logic [6:0]             node_id_o,
    output logic [3:0]             rate_idx_o,
    output cnsi_pkg::cnsi_nmt_t    nmt_state_o,
    output cnsi_pkg::cnsi_ind_t    ind_o,
    output logic                   tpdo_vld_o,
    output logic [31:0]            tpdo_data_o,
    output logic                   setp_vld_o,
    output logic [31:0]            setp_o,
    output logic                   run_green_o,
    output logic                   run_red_o,
    output logic                   err_red_o
);
    import cnsi_pkg::*;

    // timers are 24 bits wide; longer periods would wrap early
    if (FLICK_CYC < 2 || FLICK_CYC > 32'h00FF_FFFF || BLINK_CYC < 2
        || BLINK_CYC > 32'h00FF_FFFF) begin : g_bad_timing
        $error("cnsi_node: lamp timing out of range");
    end

    typedef struct packed {
        cnsi_nmt_t   nmt;
        cnsi_lss_t   lss;
        logic        sel;
        logic [6:0]  id;
        logic [3:0]  rate;
        logic [6:0]  id_pend;
        logic [3:0]  rate_pend;
        logic [6:0]  id_st;
        logic [3:0]  rate_st;
        cnsi_ind_t   ind;
        logic        tv;
        logic [31:0] td;
        logic        sv;
        logic [31:0] sd;
        logic [23:0] fcnt;
        logic        ftick;
        logic [23:0] bcnt;
        logic [3:0]  phase;
        logic        rg;
        logic        rr;
        logic        er;
    } cnsi_st_t;

    cnsi_st_t st_r;
    cnsi_st_t st_nxt;

    // a flash pattern is on in the listed phases of a 12-phase frame
    function automatic logic pat_on(input logic [3:0] ph, input logic [1:0] n);
        pat_on = (ph == 4'h0) || (n == 2'd2 && ph == 4'h2);
    endfunction

    logic addressed;
    assign addressed = req_i.nmt_dst == 7'h00 || req_i.nmt_dst == st_r.id;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.tv    = 1'b0;
        st_nxt.sv    = 1'b0;
        st_nxt.ind.lss_ok    = 1'b0;
        st_nxt.ind.lss_err   = 1'b0;
        st_nxt.ind.remap_nak = 1'b0;
        // init completes in one cycle after its entry
        if (st_r.nmt == CNSI_INIT) begin
            st_nxt.nmt = CNSI_PREOP;
        end else if (req_i.nmt_vld && addressed) begin
            case (req_i.nmt_cmd)
                NMT_START:    st_nxt.nmt = CNSI_OPER;
                NMT_STOP:     st_nxt.nmt = CNSI_STOPPED;
                NMT_PREOP:    st_nxt.nmt = CNSI_PREOP;
                NMT_RST_NODE,
                NMT_RST_COMM: st_nxt.nmt = CNSI_INIT;
                default:      st_nxt.nmt = st_r.nmt;
            endcase
        end
        st_nxt.ind.sdo_en  = (st_nxt.nmt == CNSI_PREOP)
                           || (st_nxt.nmt == CNSI_OPER);
        st_nxt.ind.tpdo_en = st_nxt.nmt == CNSI_OPER;
        st_nxt.ind.rpdo_en = st_nxt.nmt == CNSI_OPER;
        // mapping never changes; every remap attempt is answered as refused
        st_nxt.ind.remap_nak = remap_req_i;
        if (tpdo_req_i && st_r.ind.tpdo_en) begin
            st_nxt.tv = 1'b1;
            st_nxt.td = meas_i;
        end
        if (rpdo_vld_i && st_r.ind.rpdo_en) begin
            st_nxt.sv = 1'b1;
            st_nxt.sd = rpdo_data_i;
        end
        case (req_i.lss_cmd)
            LSS_GLOB: begin
                st_nxt.lss = CNSI_CONF;
            end
            LSS_SEL: begin
                if (req_i.vendor == VENDOR_ID && req_i.product == PRODUCT_ID
                    && req_i.revision == REVISION
                    && req_i.serial == serial_i) begin
                    st_nxt.lss = CNSI_CONF;
                    st_nxt.ind.lss_ok = 1'b1;
                end
            end
            LSS_SETID: begin
                if (st_r.lss == CNSI_CONF && req_i.new_id >= NODE_ID_MIN
                    && req_i.new_id <= NODE_ID_MAX) begin
                    st_nxt.id_pend = req_i.new_id;
                    st_nxt.ind.lss_ok = 1'b1;
                end else begin
                    st_nxt.ind.lss_err = 1'b1;
                end
            end
            LSS_SETBT: begin
                if (st_r.lss == CNSI_CONF
                    && req_i.new_bt <= RATE_IDX_MAX) begin
                    st_nxt.rate_pend = req_i.new_bt;
                    st_nxt.ind.lss_ok = 1'b1;
                end else begin
                    st_nxt.ind.lss_err = 1'b1;
                end
            end
            LSS_STORE: begin
                if (st_r.lss == CNSI_CONF) begin
                    st_nxt.id_st   = st_r.id_pend;
                    st_nxt.rate_st = st_r.rate_pend;
                    st_nxt.ind.lss_ok = 1'b1;
                end else begin
                    st_nxt.ind.lss_err = 1'b1;
                end
            end
            LSS_WAITC: begin
                if (st_r.lss == CNSI_CONF) begin
                    st_nxt.lss  = CNSI_WAIT;
                    st_nxt.id   = st_r.id_st;
                    st_nxt.rate = st_r.rate_st;
                end
            end
            default: ;
        endcase
        // free-running pattern timers; flicker toggles, blink steps phases
        st_nxt.fcnt = st_r.fcnt + 24'h1;
        if (st_r.fcnt >= 24'(FLICK_CYC - 1)) begin
            st_nxt.fcnt  = 24'h0;
            st_nxt.ftick = ~st_r.ftick;
        end
        st_nxt.bcnt = st_r.bcnt + 24'h1;
        if (st_r.bcnt >= 24'(BLINK_CYC - 1)) begin
            st_nxt.bcnt  = 24'h0;
            st_nxt.phase = (st_r.phase == BLINK_PHASES - 4'h1)
                         ? 4'h0 : st_r.phase + 4'h1;
        end
        st_nxt.rr = fatal_i || bus_off_i;
        if (fatal_i || bus_off_i) begin
            st_nxt.rg = 1'b0;
        end else if (rate_detect_i || st_r.lss == CNSI_CONF) begin
            st_nxt.rg = st_r.ftick;
        end else begin
            case (st_r.nmt)
                CNSI_OPER:    st_nxt.rg = 1'b1;
                CNSI_PREOP:   st_nxt.rg = ~st_r.phase[0];
                CNSI_STOPPED: st_nxt.rg = pat_on(st_r.phase, 2'd1);
                default:      st_nxt.rg = 1'b0;
            endcase
        end
        // bus off outranks all; lss flicker over error counters
        if (bus_off_i) begin
            st_nxt.er = 1'b1;
        end else if (st_r.lss == CNSI_CONF) begin
            st_nxt.er = st_r.ftick;
        end else if (err_ctrl_i) begin
            st_nxt.er = pat_on(st_r.phase, 2'd2);
        end else if (bus_warn_i) begin
            st_nxt.er = pat_on(st_r.phase, 2'd1);
        end else begin
            st_nxt.er = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r           <= '0;
            st_r.nmt       <= CNSI_INIT;
            st_r.lss       <= CNSI_WAIT;
            st_r.id        <= NODE_ID_RST;
            st_r.rate      <= RATE_IDX_RST;
            st_r.id_pend   <= NODE_ID_RST;
            st_r.rate_pend <= RATE_IDX_RST;
            st_r.id_st     <= NODE_ID_RST;
            st_r.rate_st   <= RATE_IDX_RST;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
        end
    end

    assign node_id_o   = st_r.id;
    assign rate_idx_o  = st_r.rate;
    assign nmt_state_o = st_r.nmt;
    assign ind_o       = st_r.ind;
    assign tpdo_vld_o  = st_r.tv;
    assign tpdo_data_o = st_r.td;
    assign setp_vld_o  = st_r.sv;
    assign setp_o      = st_r.sd;
    assign run_green_o = st_r.rg;
    assign run_red_o   = st_r.rr;
    assign err_red_o   = st_r.er;
endmodule // cnsi_node

// ===== logic/cnsi_pkg.sv
// cnsi_pkg: constants and carrier types for the node supervision block
// assumes a 20 MHz system clock; frames are decoded by a CAN controller
// Functional notes
// - node starts in Init and moves among Init, PreOp, Oper and Stopped.
// - service data in PreOp and Oper only, process data in Oper only.
// - unless reconfigured the node id is 0x70 and the rate is 10 kbps.
// - layer setting services may change the node id and the data rate.
// - process data mapping is fixed and remap attempts are refused.
// - sent process data carries measurements, received carries set-points.
// - run lamp: off, steady, blink, single flash, flicker or red by state.
// - error lamp: off, one or two flashes, flicker or red by bus error.
// - selection matches vendor, product, revision and a 32-bit serial.
// - layer setting has a configuration state and a waiting state.
// - a configured node id is accepted only from 0x01 through 0x7F.
// - bit-timing index 8..0 maps to 10,20,50,100,125,250,500,800k and 1M.
package cnsi_pkg;
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned FLICKER_MS    = 50;
    localparam int unsigned BLINK_MS      = 200;
    localparam int unsigned FLICKER_CYC   = CLK_HZ / 1000 * FLICKER_MS;
    localparam int unsigned BLINK_CYC     = CLK_HZ / 1000 * BLINK_MS;
    localparam logic [6:0]  NODE_ID_RST   = 7'h70;
    localparam logic [6:0]  NODE_ID_MIN   = 7'h01;
    localparam logic [6:0]  NODE_ID_MAX   = 7'h7F;
    localparam logic [3:0]  RATE_IDX_RST  = 4'h8;
    localparam logic [3:0]  RATE_IDX_MAX  = 4'h8;
    localparam logic [7:0]  NMT_START     = 8'h01;
    localparam logic [7:0]  NMT_STOP      = 8'h02;
    localparam logic [7:0]  NMT_PREOP     = 8'h80;
    localparam logic [7:0]  NMT_RST_NODE  = 8'h81;
    localparam logic [7:0]  NMT_RST_COMM  = 8'h82;
    localparam logic [3:0]  BLINK_PHASES  = 4'hC;

    typedef enum logic [3:0] {
        CNSI_INIT    = 4'b0001,
        CNSI_PREOP   = 4'b0010,
        CNSI_OPER    = 4'b0100,
        CNSI_STOPPED = 4'b1000
    } cnsi_nmt_t;

    typedef enum logic [1:0] {
        CNSI_WAIT = 2'b01,
        CNSI_CONF = 2'b10
    } cnsi_lss_t;

    typedef enum logic [2:0] {
        LSS_NONE  = 3'h0,
        LSS_GLOB  = 3'h1,
        LSS_SEL   = 3'h2,
        LSS_SETID = 3'h3,
        LSS_SETBT = 3'h4,
        LSS_STORE = 3'h5,
        LSS_WAITC = 3'h6
    } cnsi_lsscmd_t;

    typedef struct packed {
        logic         nmt_vld;
        logic [7:0]   nmt_cmd;
        logic [6:0]   nmt_dst;
        cnsi_lsscmd_t lss_cmd;
        logic [31:0]  vendor;
        logic [31:0]  product;
        logic [31:0]  revision;
        logic [31:0]  serial;
        logic [6:0]   new_id;
        logic [3:0]   new_bt;
    } cnsi_req_t;

    typedef struct packed {
        logic sdo_en;
        logic tpdo_en;
        logic rpdo_en;
        logic remap_nak;
        logic lss_ok;
        logic lss_err;
    } cnsi_ind_t;
endpackage
